/* hdl/status_filter_pkg.sv */
// Constants, encodings and bit layouts shared by the status transition filter files.
// Assumes one 20 MHz core clock and a synchronous active-low reset.

package status_filter_pkg;

    localparam int REG_W = 16;
    localparam int SET_SEL_W = 3;

    // Register set selectors.
    localparam logic [2:0] SET_MEAS = 3'h0;
    localparam logic [2:0] SET_QUES = 3'h1;
    localparam logic [2:0] SET_OPER = 3'h2;
    localparam logic [2:0] SET_TRIG = 3'h3;
    localparam logic [2:0] SET_ARM = 3'h4;
    localparam logic [2:0] SET_SEQ = 3'h5;
    localparam int NUM_SETS = 6;

    // Implemented bits of each set; all other mask bits are fixed at zero.
    localparam logic [15:0] IMPL_MEAS = 16'h0BBF;
    localparam logic [15:0] IMPL_QUES = 16'h4110;
    localparam logic [15:0] IMPL_OPER = 16'h0463;
    localparam logic [15:0] IMPL_TRIG = 16'h0002;
    localparam logic [15:0] IMPL_ARM = 16'h0002;
    localparam logic [15:0] IMPL_SEQ = 16'h0006;

    // Bit positions of the measurement set.
    localparam int MEAS_OVERFLOW = 0;
    localparam int MEAS_LOW1 = 1;
    localparam int MEAS_HIGH1 = 2;
    localparam int MEAS_LOW2 = 3;
    localparam int MEAS_HIGH2 = 4;
    localparam int MEAS_READY = 5;
    localparam int MEAS_BUF_AVAIL = 7;
    localparam int MEAS_BUF_HALF = 8;
    localparam int MEAS_BUF_FULL = 9;
    localparam int MEAS_BUF_PRETRIG = 11;
    // Questionable set.
    localparam int QUES_TEMP = 4;
    localparam int QUES_CAL = 8;
    localparam int QUES_WARN = 14;
    // Operation set.
    localparam int OPER_CAL = 0;
    localparam int OPER_MEAS = 1;
    localparam int OPER_TRIG = 5;
    localparam int OPER_ARM = 6;
    localparam int OPER_IDLE = 10;
    // Trigger, arm and sequence sets.
    localparam int TRIG_LAYER = 1;
    localparam int ARM_LAYER = 1;
    localparam int SEQ_LAYER1 = 1;
    localparam int SEQ_LAYER2 = 2;

    // Reset values match the preset state of the masks.
    localparam logic [15:0] RISE_RESET = 16'hFFFF;
    localparam logic [15:0] FALL_RESET = 16'h0000;
    localparam logic [15:0] EVENT_RESET = 16'h0000;

    typedef enum logic [2:0] {
        OP_WRITE_RISE,
        OP_WRITE_FALL,
        OP_READ_RISE,
        OP_READ_FALL,
        OP_READ_EVENT,
        OP_CLEAR_EVENT,
        OP_PRESET,
        OP_NONE
    } cmd_op_t;

endpackage

/* hdl/transition_slice.sv */
// One register set: condition history, rise and fall masks, sticky event bits.
// Assumes the condition vector is synchronous to the core clock.
`timescale 1ns/1ps

module transition_slice
    import status_filter_pkg::*;
#(
    parameter logic [15:0] IMPL = 16'hFFFF
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [REG_W-1:0] cond_i,
    input wire logic wr_rise_i,
    input wire logic wr_fall_i,
    input wire logic [REG_W-1:0] wr_data_i,
    input wire logic preset_i,
    input wire logic clear_i,
    output logic [REG_W-1:0] rise_o,
    output logic [REG_W-1:0] fall_o,
    output logic [REG_W-1:0] event_o
);

    typedef struct packed {
        logic primed;
        logic [REG_W-1:0] cond_prev;
        logic [REG_W-1:0] rise;
        logic [REG_W-1:0] fall;
        logic [REG_W-1:0] event_bits;
    } slice_state_t;

    slice_state_t state_reg;
    slice_state_t state_next;
    logic [REG_W-1:0] rose;
    logic [REG_W-1:0] fell;
    logic [REG_W-1:0] hit;

    // ************************************************************
    // Edge filter
    // ************************************************************
    always_comb begin
        // The first cycle after reset only records history, so a condition
        // already high at release is not mistaken for a fresh rising edge.
        rose = cond_i & ~state_reg.cond_prev & {REG_W{state_reg.primed}};
        fell = ~cond_i & state_reg.cond_prev & {REG_W{state_reg.primed}};
        hit = ((rose & state_reg.rise) | (fell & state_reg.fall)) & IMPL;

        state_next = state_reg;
        state_next.primed = 1'b1;
        state_next.cond_prev = cond_i;
        if (preset_i) begin
            state_next.rise = IMPL;
            state_next.fall = FALL_RESET;
        end else begin
            if (wr_rise_i) begin
                state_next.rise = wr_data_i & IMPL;
            end
            if (wr_fall_i) begin
                state_next.fall = wr_data_i & IMPL;
            end
        end
        // A new edge in the clearing cycle survives the clear.
        if (clear_i) begin
            state_next.event_bits = hit;
        end else begin
            state_next.event_bits = state_reg.event_bits | hit;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state_reg.primed <= 1'b0;
            state_reg.cond_prev <= '0;
            state_reg.rise <= RISE_RESET & IMPL;
            state_reg.fall <= FALL_RESET;
            state_reg.event_bits <= EVENT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rise_o = state_reg.rise;
    assign fall_o = state_reg.fall;
    assign event_o = state_reg.event_bits;

endmodule // transition_slice

/* hdl/status_transition_filter.sv */
// Top of the status transition filters: live condition inputs, command port, event outputs.
// Assumes status commands arrive as single-cycle strobes synchronous to core_clk_i.
`timescale 1ns/1ps

module status_transition_filter
    import status_filter_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Measurement conditions.
    input wire logic reading_overflow_i,
    input wire logic low_limit1_i,
    input wire logic high_limit1_i,
    input wire logic low_limit2_i,
    input wire logic high_limit2_i,
    input wire logic reading_ready_flag_i,
    input wire logic buffer_avail_flag_i,
    input wire logic buffer_half_flag_i,
    input wire logic buffer_full_flag_i,
    input wire logic buffer_pretrig_flag_i,
    // Questionable conditions.
    input wire logic ref_junction_bad_i,
    input wire logic cal_const_bad_i,
    input wire logic cmd_warning_i,
    // Operation conditions.
    input wire logic calibrating_i,
    input wire logic measuring_i,
    input wire logic trigger_layer_i,
    input wire logic arm_layer_i,
    input wire logic idle_i,
    // Sequence conditions.
    input wire logic arm_layer_one_flag_i,
    input wire logic arm_layer_two_flag_i,
    // Status command port.
    input wire logic cmd_valid_i,
    input wire logic [2:0] cmd_op_i,
    input wire logic [SET_SEL_W-1:0] cmd_set_i,
    input wire logic [REG_W-1:0] cmd_data_i,
    output logic rsp_valid_o,
    output logic [REG_W-1:0] rsp_data_o,
    // Event registers.
    output logic [REG_W-1:0] meas_event_o,
    output logic [REG_W-1:0] ques_event_o,
    output logic [REG_W-1:0] oper_event_o,
    output logic [REG_W-1:0] trig_event_o,
    output logic [REG_W-1:0] arm_event_o,
    output logic [REG_W-1:0] seq_event_o
);

    typedef struct packed {
        logic rsp_valid;
        logic [REG_W-1:0] rsp_data;
    } top_state_t;

    localparam logic [NUM_SETS*REG_W-1:0] IMPL_ALL =
        {IMPL_SEQ, IMPL_ARM, IMPL_TRIG, IMPL_OPER, IMPL_QUES, IMPL_MEAS};

    top_state_t state_reg;
    top_state_t state_next;
    cmd_op_t op;
    logic [REG_W-1:0] cond [NUM_SETS];
    logic [REG_W-1:0] rise [NUM_SETS];
    logic [REG_W-1:0] fall [NUM_SETS];
    logic [REG_W-1:0] events [NUM_SETS];
    logic [NUM_SETS-1:0] wr_rise;
    logic [NUM_SETS-1:0] wr_fall;
    logic [NUM_SETS-1:0] clear;
    logic preset;

    // Turns a set number into a one-hot select; codes above the last set select nothing.
    function automatic logic [NUM_SETS-1:0] set_onehot(input logic [SET_SEL_W-1:0] sel);
        logic [NUM_SETS-1:0] oh;
        oh = '0;
        if (sel < SET_SEL_W'(NUM_SETS)) begin
            oh[sel] = 1'b1;
        end
        return oh;
    endfunction

    // ************************************************************
    // Condition registers
    // ************************************************************
    // Each condition vector is the live state; the slices keep the history.
    always_comb begin
        for (int s = 0; s < NUM_SETS; s++) begin
            cond[s] = '0;
        end
        cond[SET_MEAS][MEAS_OVERFLOW] = reading_overflow_i;
        cond[SET_MEAS][MEAS_LOW1] = low_limit1_i;
        cond[SET_MEAS][MEAS_HIGH1] = high_limit1_i;
        cond[SET_MEAS][MEAS_LOW2] = low_limit2_i;
        cond[SET_MEAS][MEAS_HIGH2] = high_limit2_i;
        cond[SET_MEAS][MEAS_READY] = reading_ready_flag_i;
        cond[SET_MEAS][MEAS_BUF_AVAIL] = buffer_avail_flag_i;
        cond[SET_MEAS][MEAS_BUF_HALF] = buffer_half_flag_i;
        cond[SET_MEAS][MEAS_BUF_FULL] = buffer_full_flag_i;
        cond[SET_MEAS][MEAS_BUF_PRETRIG] = buffer_pretrig_flag_i;
        cond[SET_QUES][QUES_TEMP] = ref_junction_bad_i;
        cond[SET_QUES][QUES_CAL] = cal_const_bad_i;
        cond[SET_QUES][QUES_WARN] = cmd_warning_i;
        cond[SET_OPER][OPER_CAL] = calibrating_i;
        cond[SET_OPER][OPER_MEAS] = measuring_i;
        cond[SET_OPER][OPER_TRIG] = trigger_layer_i;
        cond[SET_OPER][OPER_ARM] = arm_layer_i;
        cond[SET_OPER][OPER_IDLE] = idle_i;
        cond[SET_TRIG][TRIG_LAYER] = trigger_layer_i;
        cond[SET_ARM][ARM_LAYER] = arm_layer_i;
        cond[SET_SEQ][SEQ_LAYER1] = arm_layer_one_flag_i;
        cond[SET_SEQ][SEQ_LAYER2] = arm_layer_two_flag_i;
    end

    // ************************************************************
    // Command decode
    // ************************************************************
    always_comb begin
        op = cmd_valid_i ? cmd_op_t'(cmd_op_i) : OP_NONE;
        wr_rise = (op == OP_WRITE_RISE) ? set_onehot(cmd_set_i) : '0;
        wr_fall = (op == OP_WRITE_FALL) ? set_onehot(cmd_set_i) : '0;
        clear = (op == OP_CLEAR_EVENT) ? set_onehot(cmd_set_i) : '0;
        preset = (op == OP_PRESET);
    end

    // ************************************************************
    // Filter slices
    // ************************************************************
    for (genvar s = 0; s < NUM_SETS; s++) begin : g_set
        transition_slice #(
            .IMPL(IMPL_ALL[s*REG_W +: REG_W])
        ) u_slice (
            .core_clk_i(core_clk_i),
            .rst_b_i(rst_b_i),
            .cond_i(cond[s]),
            .wr_rise_i(wr_rise[s]),
            .wr_fall_i(wr_fall[s]),
            .wr_data_i(cmd_data_i),
            .preset_i(preset),
            .clear_i(clear[s]),
            .rise_o(rise[s]),
            .fall_o(fall[s]),
            .event_o(events[s])
        );
    end

    // ************************************************************
    // Query response
    // ************************************************************
    // Reads answer one cycle after the strobe; an unknown set reads as zero.
    always_comb begin
        state_next = state_reg;
        state_next.rsp_valid = 1'b0;
        if (op == OP_READ_RISE || op == OP_READ_FALL || op == OP_READ_EVENT) begin
            state_next.rsp_valid = 1'b1;
            state_next.rsp_data = '0;
            if (cmd_set_i < SET_SEL_W'(NUM_SETS)) begin
                case (op)
                    OP_READ_RISE: state_next.rsp_data = rise[cmd_set_i];
                    OP_READ_FALL: state_next.rsp_data = fall[cmd_set_i];
                    default: state_next.rsp_data = events[cmd_set_i];
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state_reg.rsp_valid <= 1'b0;
            state_reg.rsp_data <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rsp_valid_o = state_reg.rsp_valid;
    assign rsp_data_o = state_reg.rsp_data;
    assign meas_event_o = events[SET_MEAS];
    assign ques_event_o = events[SET_QUES];
    assign oper_event_o = events[SET_OPER];
    assign trig_event_o = events[SET_TRIG];
    assign arm_event_o = events[SET_ARM];
    assign seq_event_o = events[SET_SEQ];

endmodule // status_transition_filter

/* bench/status_transition_filter_properties.sv */
// Concurrent checks on the ports of the status transition filter top.
// Assumes it is bound to status_transition_filter and sees only its ports.
`timescale 1ns/1ps

module status_transition_filter_properties
    import status_filter_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic reading_overflow_i,
    input wire logic reading_ready_flag_i,
    input wire logic buffer_full_flag_i,
    input wire logic ref_junction_bad_i,
    input wire logic idle_i,
    input wire logic trigger_layer_i,
    input wire logic arm_layer_i,
    input wire logic arm_layer_two_flag_i,
    input wire logic cmd_valid_i,
    input wire logic [2:0] cmd_op_i,
    input wire logic [SET_SEL_W-1:0] cmd_set_i,
    input wire logic [REG_W-1:0] cmd_data_i,
    input wire logic rsp_valid_o,
    input wire logic [REG_W-1:0] rsp_data_o,
    input wire logic [REG_W-1:0] meas_event_o,
    input wire logic [REG_W-1:0] ques_event_o,
    input wire logic [REG_W-1:0] oper_event_o,
    input wire logic [REG_W-1:0] trig_event_o,
    input wire logic [REG_W-1:0] arm_event_o,
    input wire logic [REG_W-1:0] seq_event_o
);
    // ************************************************************
    // Chosen event bits rise only after a condition change, sequence bits drop only on a clear; fall masks read back as written (sequence) and as preset.
    // ************************************************************
    logic clr_seq_q;

    always_ff @(posedge core_clk_i) begin
        clr_seq_q <= cmd_valid_i && cmd_op_i == OP_CLEAR_EVENT && cmd_set_i == SET_SEQ;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_ovf;
        $rose(meas_event_o[0]) |-> $past(reading_overflow_i) != $past(reading_overflow_i, 2);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow event without change");
    property p_ready;
        $rose(meas_event_o[5]) |-> $past(reading_ready_flag_i) != $past(reading_ready_flag_i, 2);
    endproperty
    a_ready: assert property (p_ready) else $error("ready event without change");
    property p_full;
        $rose(meas_event_o[9]) |-> $past(buffer_full_flag_i) != $past(buffer_full_flag_i, 2);
    endproperty
    a_full: assert property (p_full) else $error("full event without change");
    property p_junc;
        $rose(ques_event_o[4]) |-> $past(ref_junction_bad_i) != $past(ref_junction_bad_i, 2);
    endproperty
    a_junc: assert property (p_junc) else $error("junction event without change");
    property p_idle;
        $rose(oper_event_o[10]) |-> $past(idle_i) != $past(idle_i, 2);
    endproperty
    a_idle: assert property (p_idle) else $error("idle event without change");
    property p_trig;
        $rose(trig_event_o[1]) |-> $past(trigger_layer_i) != $past(trigger_layer_i, 2);
    endproperty
    a_trig: assert property (p_trig) else $error("trigger event without change");
    property p_arm;
        $rose(arm_event_o[1]) |-> $past(arm_layer_i) != $past(arm_layer_i, 2);
    endproperty
    a_arm: assert property (p_arm) else $error("arm event without change");
    property p_arm_layer_two_flag;
        $rose(seq_event_o[2]) |-> $past(arm_layer_two_flag_i) != $past(arm_layer_two_flag_i, 2);
    endproperty
    a_arm_layer_two_flag: assert property (p_arm_layer_two_flag) else $error("layer two event without change");
    property p_unimpl;
        (seq_event_o & ~IMPL_SEQ) == 16'h0000 && (meas_event_o & ~IMPL_MEAS) == 16'h0000;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented event bit set");
    property p_sticky;
        (|($past(seq_event_o) & ~seq_event_o)) && $past(rst_b_i) |-> clr_seq_q;
    endproperty
    a_sticky: assert property (p_sticky) else $error("event bit dropped without clear");
    property p_wr_rd;
        (cmd_valid_i && cmd_op_i == OP_WRITE_FALL && cmd_set_i == SET_SEQ) ##1
        (cmd_valid_i && cmd_op_i == OP_READ_FALL && cmd_set_i == SET_SEQ)
        |=> rsp_valid_o && rsp_data_o == ($past(cmd_data_i, 2) & IMPL_SEQ);
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("fall mask readback differs");
    property p_preset;
        (cmd_valid_i && cmd_op_i == OP_PRESET) ##1
        (cmd_valid_i && cmd_op_i == OP_READ_FALL) |=> rsp_data_o == 16'h0000;
    endproperty
    a_preset: assert property (p_preset) else $error("fall mask not cleared by preset");
endmodule // status_transition_filter_properties

/* bench/status_transition_filter_test.sv */
// Self-checking bench for the status transition filter: mask access and edge latching.
// Assumes the design files and the property checker are compiled before this file.
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module status_transition_filter_test
    import status_filter_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [15:0] mc = 16'h0000;
    logic [15:0] sc = 16'h0000;
    logic cmd_valid_i = 1'b0;
    logic [2:0] cmd_op_i = 3'h7;
    logic [2:0] cmd_set_i = 3'h0;
    logic [15:0] cmd_data_i = 16'h0000;
    logic rsp_valid_o;
    logic [15:0] rsp_data_o, meas_e, ques_e, oper_e, trig_e, arm_e, seq_e;
    logic [15:0] evs [6];
    logic [15:0] impl [6] = '{IMPL_MEAS, IMPL_QUES, IMPL_OPER, IMPL_TRIG, IMPL_ARM, IMPL_SEQ};
    int fails = 0;
    int checks = 0;

    always #25 core_clk_i = ~core_clk_i;
    always_comb evs = '{meas_e, ques_e, oper_e, trig_e, arm_e, seq_e};

    // All non-sequence conditions follow one vector so that every set toggles together.
    status_transition_filter u_dut (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .reading_overflow_i(mc[0]), .low_limit1_i(mc[1]), .high_limit1_i(mc[2]),
        .low_limit2_i(mc[3]), .high_limit2_i(mc[4]), .reading_ready_flag_i(mc[5]),
        .buffer_avail_flag_i(mc[7]), .buffer_half_flag_i(mc[8]), .buffer_full_flag_i(mc[9]),
        .buffer_pretrig_flag_i(mc[11]), .ref_junction_bad_i(mc[4]), .cal_const_bad_i(mc[8]),
        .cmd_warning_i(mc[14]), .calibrating_i(mc[0]), .measuring_i(mc[1]),
        .trigger_layer_i(mc[5]), .arm_layer_i(mc[6]), .idle_i(mc[10]),
        .arm_layer_one_flag_i(sc[1]), .arm_layer_two_flag_i(sc[2]),
        .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_set_i(cmd_set_i),
        .cmd_data_i(cmd_data_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
        .meas_event_o(meas_e), .ques_event_o(ques_e), .oper_event_o(oper_e),
        .trig_event_o(trig_e), .arm_event_o(arm_e), .seq_event_o(seq_e)
    );

    // ************************************************************
    // Command port and condition tasks.
    // ************************************************************
    task automatic drv(input logic [2:0] op, input logic [2:0] set, input logic [15:0] data);
        @(posedge core_clk_i);
        cmd_valid_i <= 1'b1;
        cmd_op_i <= op;
        cmd_set_i <= set;
        cmd_data_i <= data;
    endtask

    task automatic idle();
        @(posedge core_clk_i);
        cmd_valid_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [2:0] op, input logic [2:0] set, input logic [15:0] exp);
        drv(op, set, 16'h0000);
        idle();
        `CHK("response strobe", 1'b1, rsp_valid_o)
        `CHK("response data", exp, rsp_data_o)
    endtask

    task automatic wr_all(input logic [2:0] op, input logic [15:0] data);
        for (int s = 0; s < 6; s++) drv(op, 3'(s), data);
        idle();
    endtask

    task automatic step(input logic [15:0] m, input logic [15:0] s);
        @(posedge core_clk_i);
        mc <= m;
        sc <= s;
        @(posedge core_clk_i);
        #1;
    endtask

    task automatic ev_chk(input logic all_set);
        for (int s = 0; s < 6; s++) `CHK("event register", all_set ? impl[s] : 16'h0000, evs[s])
    endtask

    task automatic complete_run();
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ************************************************************
    // Test sequence and watchdog.
    // ************************************************************
    initial begin
        repeat (3000) @(posedge core_clk_i);
        fails++;
        complete_run();
    end

    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        for (int s = 0; s < 6; s++) begin
            rd(OP_READ_RISE, 3'(s), impl[s]);
            rd(OP_READ_FALL, 3'(s), 16'h0000);
        end
        wr_all(OP_WRITE_FALL, 16'hFFFF);
        for (int s = 0; s < 6; s++) rd(OP_READ_FALL, 3'(s), impl[s]);
        rd(OP_READ_FALL, 3'h6, 16'h0000);
        wr_all(OP_WRITE_RISE, 16'h0000);
        step(16'hFFFF, 16'h0006);
        ev_chk(1'b0);
        step(16'h0000, 16'h0000);
        ev_chk(1'b1);
        wr_all(OP_CLEAR_EVENT, 16'h0000);
        ev_chk(1'b0);
        wr_all(OP_WRITE_RISE, 16'hFFFF);
        wr_all(OP_WRITE_FALL, 16'h0000);
        step(16'hFFFF, 16'h0006);
        ev_chk(1'b1);
        wr_all(OP_CLEAR_EVENT, 16'h0000);
        step(16'h0000, 16'h0000);
        ev_chk(1'b0);
        drv(OP_WRITE_RISE, SET_SEQ, 16'h0000);
        drv(OP_WRITE_FALL, SET_SEQ, 16'hFFFB);
        rd(OP_READ_FALL, SET_SEQ, 16'h0002);
        drv(OP_WRITE_FALL, SET_SEQ, 16'h0004);
        rd(OP_READ_FALL, SET_SEQ, 16'h0004);
        step(16'h0000, 16'h0006);
        step(16'h0000, 16'h0000);
        `CHK("sequence event", 16'h0004, seq_e)
        step(16'h0000, 16'h0006);
        `CHK("sequence event", 16'h0004, seq_e)
        drv(OP_PRESET, 3'h0, 16'h0000);
        rd(OP_READ_FALL, SET_SEQ, 16'h0000);
        rd(OP_READ_RISE, SET_SEQ, 16'h0006);
        rd(OP_READ_EVENT, SET_SEQ, 16'h0004);
        // Codes without a set, and the no-op code, must leave the sequence fall mask and event bits alone.
        drv(OP_WRITE_FALL, 3'h6, 16'hFFFF);
        drv(OP_NONE, SET_SEQ, 16'hFFFF);
        drv(OP_CLEAR_EVENT, 3'h7, 16'h0000);
        rd(OP_READ_FALL, SET_SEQ, 16'h0000);
        rd(OP_READ_EVENT, SET_SEQ, 16'h0004);
        // Conditions already high across a reset release must not look like fresh edges.
        @(posedge core_clk_i);
        rst_b_i <= 1'b0;
        mc <= 16'hFFFF;
        sc <= 16'h0006;
        repeat (2) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1;
        ev_chk(1'b0);
        rd(OP_READ_RISE, SET_SEQ, 16'h0006);
        rd(OP_READ_FALL, SET_SEQ, 16'h0000);
        // A single condition dropping must land on its own event bit only.
        drv(OP_WRITE_FALL, SET_MEAS, 16'hFFFF);
        idle();
        step(16'hFDFF, 16'h0006);
        `CHK("measurement event", 16'h0200, meas_e)
        `CHK("questionable event", 16'h0000, ques_e)
        complete_run();
    end
endmodule // status_transition_filter_test

bind status_transition_filter status_transition_filter_properties u_props (.*);
